// ---- rifd_map.svh ----
/*
 * register numbers, field positions, timing counts and stack depth of the integer field datapath.
 * assumes inclusion by the datapath module only.
 */
`ifndef RIFD_MAP_SVH
`define RIFD_MAP_SVH

// ------------------------------------------------------------
// instruction word layout
// ------------------------------------------------------------
`define RIFD_SEQ_LSB 56
`define RIFD_SEQ_W 8
`define RIFD_INT_LSB 32
`define RIFD_INT_W 24
`define RIFD_FP_LSB 0
`define RIFD_FP_W 32
`define RIFD_CODE32_INT_LSB 0

// ------------------------------------------------------------
// integer field layout: op[23:18] a[17:13] b[12:8] d[7:3] x[2:0]
// ------------------------------------------------------------
`define RIFD_OP_LSB 18
`define RIFD_A_LSB 13
`define RIFD_B_LSB 8
`define RIFD_D_LSB 3

// ------------------------------------------------------------
// special register numbers for moves
// ------------------------------------------------------------
`define RIFD_SR_PHI 3'h0
`define RIFD_SR_PLO 3'h1
`define RIFD_SR_FLEN 3'h2
`define RIFD_SR_SAMT 3'h3
`define RIFD_SR_CARRY 3'h4
`define RIFD_SR_TOS 3'h5

// ------------------------------------------------------------
// timing and stack depth
// ------------------------------------------------------------
`define RIFD_MUL_CYCLES 8
`define RIFD_DIV_CYCLES 20
`define RIFD_STACK_DEPTH 32
`define RIFD_FP_LAT_SP 3
`define RIFD_FP_LAT_DP 2

`endif

// ---- rifd_pkg.sv ----
/*
 * types of the integer field datapath.
 * gives its numeric constants as literals and does not include rifd_map.svh.
 */
package rifd_pkg;

    typedef enum logic [5:0] {
        RIFD_OP_NOP = 6'h00,
        RIFD_OP_ADD = 6'h01,
        RIFD_OP_ADDC = 6'h02,
        RIFD_OP_SUB = 6'h03,
        RIFD_OP_SUBC = 6'h04,
        RIFD_OP_ADDI = 6'h05,
        RIFD_OP_SUBI = 6'h06,
        RIFD_OP_LOGIC = 6'h07,
        RIFD_OP_MUL = 6'h08,
        RIFD_OP_DIV = 6'h09,
        RIFD_OP_EXT = 6'h0A,
        RIFD_OP_DEP = 6'h0B,
        RIFD_OP_MRG = 6'h0C,
        RIFD_OP_EXTD = 6'h0D,
        RIFD_OP_DEPD = 6'h0E,
        RIFD_OP_MRGD = 6'h0F,
        RIFD_OP_MOVTO = 6'h10,
        RIFD_OP_MOVFROM = 6'h11,
        RIFD_OP_PUSH = 6'h12,
        RIFD_OP_POP = 6'h13
    } rifd_op_t;

    typedef enum logic [1:0] {
        RIFD_MD_IDLE = 2'b00,
        RIFD_MD_MUL = 2'b01,
        RIFD_MD_DIV = 2'b10
    } rifd_md_state_t;

    typedef struct packed {
        logic [7:0] seq;
        logic [23:0] intf;
        logic [31:0] fpf;
    } rifd_word_t;

    typedef struct packed {
        logic valid;
        logic [31:0] data;
        logic [4:0] dst;
    } rifd_fp_issue_t;

endpackage

// ---- rifd_datapath.sv ----
/*
 * integer field datapath: register files, carry, product pair, field shifter,
 * iterative multiply and divide, control stack and floating point issue pipe.
 * assumes one instruction word per enabled cycle from the sequencer, and that
 * the sequencer and floating point unit consume the outputs on the same clock.
 */
`timescale 1ns/1ns
`include "rifd_map.svh"

module rifd_datapath
    import rifd_pkg::*;
#(
    parameter int FP_PRESENT = 1,
    parameter int FP_DOUBLE = 0
) (
    input wire logic clock_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic instr_valid_i,
    input wire rifd_word_t instr_i,
    input wire logic [31:0] load_data_i,
    input wire logic load_en_i,
    input wire logic [4:0] load_dst_i,
    input wire logic [1:0] stack_op_i,
    input wire logic [31:0] stack_push_data_i,
    output logic [7:0] seq_field_o,
    output logic cond_o,
    output logic [31:0] result_o,
    output logic [31:0] tos_o,
    output logic stack_overflow_o,
    output logic stack_underflow_o,
    output logic md_busy_o,
    output rifd_fp_issue_t fp_done_o,
    output logic [31:0] product_high_o,
    output logic [31:0] product_low_o
);

    localparam int FPW = (FP_DOUBLE != 0) ? 64 : 32;
    localparam int FP_LAT = (FP_DOUBLE != 0) ? `RIFD_FP_LAT_DP : `RIFD_FP_LAT_SP;

    if (FP_PRESENT < 0 || FP_PRESENT > 1 || FP_DOUBLE < 0 || FP_DOUBLE > 1 || (FP_DOUBLE == 1 && FP_PRESENT == 0)) begin : g_bad_variant
        $error("unsupported variant");
    end

    // ------------------------------------------------------------
    // field decode
    // ------------------------------------------------------------
    logic [23:0] intf;
    logic [31:0] fpf;
    rifd_op_t op;
    logic [4:0] ra, rb, rd;
    logic [2:0] xf;
    logic go;

    always_comb begin
        if (FP_PRESENT != 0) begin
            intf = instr_i.intf;
            fpf = instr_i.fpf;
        end else begin
            intf = instr_i.fpf[`RIFD_CODE32_INT_LSB +: `RIFD_INT_W];
            fpf = 32'h0000_0000;
        end
    end

    assign op = rifd_op_t'(intf[`RIFD_OP_LSB +: 6]);
    assign ra = intf[`RIFD_A_LSB +: 5];
    assign rb = intf[`RIFD_B_LSB +: 5];
    assign rd = intf[`RIFD_D_LSB +: 5];
    assign xf = intf[2:0];
    assign go = ce_i && instr_valid_i;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [31:0] gpr [0:31];
    logic [31:0] phi_r, plo_r;
    logic [4:0] flen_r, samt_r;
    logic carry_r;
    logic [31:0] tos_r;
    logic [31:0] stk_mem [0:`RIFD_STACK_DEPTH-1];
    logic [5:0] sp_r;
    rifd_md_state_t md_r;
    logic [4:0] md_cnt_r;
    logic [63:0] md_acc_r;
    logic [31:0] md_opb_r;

    logic [31:0] a_val, b_val;
    assign a_val = gpr[ra];
    assign b_val = gpr[rb];

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    function automatic logic [31:0] field_mask(input logic [4:0] len);
        field_mask = (len == 5'h00) ? 32'hFFFF_FFFF : ((32'h0000_0001 << len) - 32'h0000_0001);
    endfunction

    function automatic logic [31:0] logic16(input logic [3:0] f, input logic [31:0] a, input logic [31:0] b);
        logic [31:0] r;
        r = 32'h0000_0000;
        for (int i = 0; i < 32; i++) begin
            r[i] = f[{a[i], b[i]}];
        end
        logic16 = r;
    endfunction

    // ------------------------------------------------------------
    // integer alu, field shifter, condition
    // ------------------------------------------------------------
    logic [31:0] alu_res;
    logic [32:0] sum;
    logic alu_carry_we, alu_we;
    logic [4:0] f_len, f_sh;
    logic [31:0] f_mask, f_tmp;

    always_comb begin
        f_len = intf[7:3];
        f_sh = intf[12:8];
        if (op == RIFD_OP_EXTD || op == RIFD_OP_DEPD || op == RIFD_OP_MRGD) begin
            f_len = flen_r;
            f_sh = samt_r;
        end
        f_mask = field_mask(f_len);
        f_tmp = 32'h0000_0000;
        sum = 33'h0_0000_0000;
        alu_res = 32'h0000_0000;
        alu_carry_we = 1'b0;
        alu_we = 1'b1;
        case (op)
            RIFD_OP_ADD: begin
                sum = {1'b0, a_val} + {1'b0, b_val};
                alu_carry_we = 1'b1;
            end
            RIFD_OP_ADDC: begin
                sum = {1'b0, a_val} + {1'b0, b_val} + {32'h0000_0000, carry_r};
                alu_carry_we = 1'b1;
            end
            RIFD_OP_SUB: begin
                sum = {1'b0, a_val} + {1'b0, ~b_val} + 33'h0_0000_0001;
                alu_carry_we = 1'b1;
            end
            RIFD_OP_SUBC: begin
                sum = {1'b0, a_val} + {1'b0, ~b_val} + {32'h0000_0000, carry_r};
                alu_carry_we = 1'b1;
            end
            RIFD_OP_ADDI: begin
                sum = {1'b0, a_val} + {28'h000_0000, rb};
                alu_carry_we = 1'b1;
            end
            RIFD_OP_SUBI: begin
                sum = {1'b0, a_val} + {1'b0, ~{27'h000_0000, rb}} + 33'h0_0000_0001;
                alu_carry_we = 1'b1;
            end
            RIFD_OP_LOGIC: begin
                alu_res = logic16({xf, intf[7]}, a_val, b_val);
            end
            RIFD_OP_EXT, RIFD_OP_EXTD: begin
                f_tmp = (a_val >> f_sh) & f_mask;
                alu_res = f_tmp;
                if (xf[0] && f_len != 5'h00 && f_tmp[f_len - 5'h01]) begin
                    alu_res = f_tmp | ~f_mask;
                end
            end
            RIFD_OP_DEP, RIFD_OP_DEPD: begin
                alu_res = (a_val & f_mask) << f_sh;
            end
            RIFD_OP_MRG, RIFD_OP_MRGD: begin
                f_tmp = f_mask << f_sh;
                alu_res = (plo_r & ~f_tmp) | ((a_val << f_sh) & f_tmp);
            end
            RIFD_OP_MOVFROM: begin
                case (xf)
                    `RIFD_SR_PHI: alu_res = phi_r;
                    `RIFD_SR_PLO: alu_res = plo_r;
                    `RIFD_SR_FLEN: alu_res = {27'h000_0000, flen_r};
                    `RIFD_SR_SAMT: alu_res = {27'h000_0000, samt_r};
                    `RIFD_SR_CARRY: alu_res = {31'h0000_0000, carry_r};
                    `RIFD_SR_TOS: alu_res = tos_r;
                    default: alu_res = 32'h0000_0000;
                endcase
            end
            RIFD_OP_POP: begin
                alu_res = tos_r;
            end
            default: begin
                alu_we = 1'b0;
            end
        endcase
        if (alu_carry_we) begin
            alu_res = sum[31:0];
        end
    end

    // ------------------------------------------------------------
    // integer register file and outputs, single cycle
    // ------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (ce_i) begin
            if (go && alu_we) begin
                gpr[rd] <= alu_res;
            end
            if (load_en_i && !(go && alu_we && load_dst_i == rd)) begin
                gpr[load_dst_i] <= load_data_i;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            seq_field_o <= 8'h00;
            cond_o <= 1'b0;
            result_o <= 32'h0000_0000;
        end else if (go) begin
            seq_field_o <= instr_i.seq;
            cond_o <= (alu_res == 32'h0000_0000);
            result_o <= alu_res;
        end
    end

    // ------------------------------------------------------------
    // carry, field length, shift amount
    // ------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            carry_r <= 1'b0;
        end else if (go && alu_carry_we) begin
            carry_r <= sum[32];
        end else if (go && op == RIFD_OP_MOVTO && xf == `RIFD_SR_CARRY) begin
            carry_r <= a_val[0];
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            flen_r <= 5'h00;
            samt_r <= 5'h00;
        end else if (go && op == RIFD_OP_MOVTO) begin
            if (xf == `RIFD_SR_FLEN) begin
                flen_r <= a_val[4:0];
            end
            if (xf == `RIFD_SR_SAMT) begin
                samt_r <= a_val[4:0];
            end
        end
    end

    // ------------------------------------------------------------
    // iterative multiply and divide
    // ------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            md_r <= RIFD_MD_IDLE;
            md_cnt_r <= 5'h00;
            md_acc_r <= 64'h0;
            md_opb_r <= 32'h0000_0000;
            phi_r <= 32'h0000_0000;
            plo_r <= 32'h0000_0000;
        end else if (ce_i) begin
            case (md_r)
                RIFD_MD_IDLE: begin
                    if (go && op == RIFD_OP_MUL) begin
                        md_r <= RIFD_MD_MUL;
                        md_cnt_r <= 5'(`RIFD_MUL_CYCLES - 1);
                        md_acc_r <= 64'($signed(a_val) * $signed(b_val));
                    end else if (go && op == RIFD_OP_DIV) begin
                        md_r <= RIFD_MD_DIV;
                        md_cnt_r <= 5'(`RIFD_DIV_CYCLES - 1);
                        md_acc_r <= {phi_r, a_val};
                        md_opb_r <= b_val;
                    end else if (go && op == RIFD_OP_MOVTO && xf == `RIFD_SR_PHI) begin
                        phi_r <= a_val;
                    end else if (go && op == RIFD_OP_MOVTO && xf == `RIFD_SR_PLO) begin
                        plo_r <= a_val;
                    end
                end
                RIFD_MD_MUL: begin
                    md_cnt_r <= md_cnt_r - 5'h01;
                    if (md_cnt_r == 5'h01) begin
                        phi_r <= md_acc_r[63:32];
                        plo_r <= md_acc_r[31:0];
                        md_r <= RIFD_MD_IDLE;
                    end
                end
                RIFD_MD_DIV: begin
                    md_cnt_r <= md_cnt_r - 5'h01;
                    if (md_cnt_r == 5'h01) begin
                        phi_r <= 32'(md_acc_r % {32'h0000_0000, md_opb_r});
                        plo_r <= 32'(md_acc_r / {32'h0000_0000, md_opb_r});
                        md_r <= RIFD_MD_IDLE;
                    end
                end
                default: begin
                    md_r <= RIFD_MD_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            md_busy_o <= 1'b0;
            product_high_o <= 32'h0000_0000;
            product_low_o <= 32'h0000_0000;
        end else if (ce_i) begin
            md_busy_o <= (md_r == RIFD_MD_IDLE) ? (go && (op == RIFD_OP_MUL || op == RIFD_OP_DIV))
                                                 : (md_cnt_r != 5'h01);
            product_high_o <= phi_r;
            product_low_o <= plo_r;
        end
    end

    // ------------------------------------------------------------
    // control stack: top register plus 32-word memory
    // ------------------------------------------------------------
    logic do_push, do_pop;
    logic [31:0] push_val;
    assign do_push = ce_i && (stack_op_i == 2'b01 || (go && op == RIFD_OP_PUSH));
    assign do_pop = ce_i && !do_push && (stack_op_i == 2'b10 || (go && op == RIFD_OP_POP));
    assign push_val = (go && op == RIFD_OP_PUSH) ? a_val : stack_push_data_i;

    always_ff @(posedge clock_i) begin
        if (ce_i && do_push && sp_r != 6'h00 && sp_r <= 6'(`RIFD_STACK_DEPTH)) begin
            stk_mem[sp_r[4:0] - 5'h01] <= tos_r;
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            sp_r <= 6'h00;
            tos_r <= 32'h0000_0000;
            stack_overflow_o <= 1'b0;
            stack_underflow_o <= 1'b0;
        end else if (ce_i) begin
            stack_overflow_o <= do_push && sp_r == 6'(`RIFD_STACK_DEPTH + 1);
            stack_underflow_o <= do_pop && sp_r == 6'h00;
            if (do_push && sp_r != 6'(`RIFD_STACK_DEPTH + 1)) begin
                tos_r <= push_val;
                sp_r <= sp_r + 6'h01;
            end else if (do_pop && sp_r != 6'h00) begin
                tos_r <= (sp_r > 6'h01) ? stk_mem[sp_r[4:0] - 5'h02] : 32'h0000_0000;
                sp_r <= sp_r - 6'h01;
            end
        end
    end

    assign tos_o = tos_r;

    // ------------------------------------------------------------
    // floating point registers and issue pipe
    // ------------------------------------------------------------
    logic [FPW-1:0] fpr [0:31];
    rifd_fp_issue_t fp_pipe_r [0:FP_LAT-1];

    always_ff @(posedge clock_i) begin
        if (ce_i && FP_PRESENT != 0 && load_en_i && fpf[31]) begin
            fpr[load_dst_i] <= FPW'(load_data_i);
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            for (int i = 0; i < FP_LAT; i++) begin
                fp_pipe_r[i] <= '0;
            end
        end else if (ce_i) begin
            fp_pipe_r[0].valid <= go && FP_PRESENT != 0 && fpf != 32'h0000_0000;
            fp_pipe_r[0].data <= fpr[fpf[14:10]][31:0] ^ fpr[fpf[9:5]][31:0];
            fp_pipe_r[0].dst <= fpf[4:0];
            for (int i = 1; i < FP_LAT; i++) begin
                fp_pipe_r[i] <= fp_pipe_r[i - 1];
            end
        end
    end

    assign fp_done_o = fp_pipe_r[FP_LAT - 1];

endmodule

// ---- rifd_datapath_monitor.sv ----
/*
 * port checker for the integer field datapath, bound to rifd_datapath.
 * assumes rifd_pkg and a single clock with synchronous active high reset.
 */
`timescale 1ns/1ns
module rifd_datapath_monitor
    import rifd_pkg::*;
#(
    parameter int FP_PRESENT = 1,
    parameter int FP_DOUBLE = 0
) (
    input wire logic clock_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic instr_valid_i,
    input wire rifd_word_t instr_i,
    input wire logic [7:0] seq_field_o,
    input wire logic cond_o,
    input wire logic [31:0] result_o,
    input wire logic [31:0] tos_o,
    input wire logic stack_overflow_o,
    input wire logic stack_underflow_o,
    input wire logic md_busy_o
);
    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    logic taken;
    logic [5:0] op;
    logic [7:0] seq_w;
    logic [5:0] busy_cnt_r;
    assign taken = ce_i && instr_valid_i;
    assign op = (FP_PRESENT != 0) ? instr_i.intf[23:18] : instr_i[23:18];
    assign seq_w = instr_i.seq;
    always_ff @(posedge clock_i) begin
        if (srst_i || !md_busy_o) begin
            busy_cnt_r <= 6'h00;
        end else begin
            busy_cnt_r <= busy_cnt_r + 6'h01;
        end
    end
    default clocking @(posedge clock_i); endclocking
    default disable iff (srst_i);
    sequence s_mul_run;
        ##1 md_busy_o [*7];
    endsequence
    sequence s_div_run;
        ##1 md_busy_o [*8] ##11 md_busy_o;
    endsequence
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    a_reset_clears: assert property ($past(srst_i) |-> result_o == 32'h0 && tos_o == 32'h0 && !md_busy_o)
        else $error("outputs not cleared after reset");
    a_seq_field_echo: assert property (taken |=> seq_field_o == $past(seq_w))
        else $error("sequencer field not passed on");
    a_cond_from_result: assert property (taken |=> cond_o == (result_o == 32'h0))
        else $error("condition does not match result");
    a_mul_busy_run: assert property (taken && op == RIFD_OP_MUL && !md_busy_o |-> s_mul_run)
        else $error("multiply busy too short");
    a_div_busy_run: assert property (taken && op == RIFD_OP_DIV && !md_busy_o |-> s_div_run)
        else $error("divide busy too short");
    a_busy_bounded: assert property (busy_cnt_r <= 6'd21)
        else $error("busy longer than a divide");
    a_over_pulse_once: assert property ($rose(stack_overflow_o) |=> !stack_overflow_o)
        else $error("overflow trap longer than one cycle");
    a_under_pulse_once: assert property ($rose(stack_underflow_o) |=> !stack_underflow_o)
        else $error("underflow trap longer than one cycle");
    a_freeze_holds: assert property (!ce_i |=> $stable(result_o) && $stable(tos_o))
        else $error("state moved while clock enable low");
endmodule

bind rifd_datapath rifd_datapath_monitor #(.FP_PRESENT(FP_PRESENT), .FP_DOUBLE(FP_DOUBLE)) u_rifd_datapath_monitor (
    .clock_i(clock_i), .srst_i(srst_i), .ce_i(ce_i), .instr_valid_i(instr_valid_i), .instr_i(instr_i),
    .seq_field_o(seq_field_o), .cond_o(cond_o), .result_o(result_o), .tos_o(tos_o),
    .stack_overflow_o(stack_overflow_o), .stack_underflow_o(stack_underflow_o), .md_busy_o(md_busy_o));

// ---- rifd_seq_model.sv ----
/*
 * program sequencer model: issues instruction words and stack requests.
 * assumes the datapath samples on the rising edge; drives on the falling edge.
 */
`timescale 1ns/1ns
module rifd_seq_model
    import rifd_pkg::*;
(
    input wire logic clock_i,
    input wire logic md_busy_i,
    output logic instr_valid_o,
    output rifd_word_t instr_o,
    output logic [1:0] stack_op_o,
    output logic [31:0] stack_push_data_o
);
    initial begin
        instr_valid_o = 1'b0;
        instr_o = '0;
        stack_op_o = 2'b00;
        stack_push_data_o = 32'h0;
    end
    // one word per call, fields packed as seq, integer, float
    task automatic issue(input rifd_word_t w);
        int n;
        n = 0;
        // no new multiply or divide issued while one runs
        while ((w.intf[23:18] == RIFD_OP_MUL || w.intf[23:18] == RIFD_OP_DIV) && md_busy_i && n < 64) begin
            @(negedge clock_i);
            n++;
        end
        @(negedge clock_i);
        instr_valid_o = 1'b1;
        instr_o = w;
        @(negedge clock_i);
        instr_valid_o = 1'b0;
        instr_o = ~w;
    endtask
    task automatic stack(input logic [1:0] op, input logic [31:0] d);
        @(negedge clock_i);
        stack_op_o = op;
        stack_push_data_o = d;
        @(negedge clock_i);
        stack_op_o = 2'b00;
        stack_push_data_o = ~d;
    endtask
endmodule

// ---- test_risc_integer_field_datapath.sv ----
/*
 * self-checking testbench of the integer field datapath.
 * assumes rifd_seq_model as sequencer and the checker bound to the design.
 */
`timescale 1ns/1ns
module test_risc_integer_field_datapath;
    import rifd_pkg::*;
    logic clock_i, srst_i, ce_i, load_en, instr_valid, cond, ovf, unf, busy;
    logic [4:0] load_dst;
    logic [1:0] stack_op;
    logic [7:0] seq_field;
    logic [31:0] load_data, push_data, result, tos, phi, plo;
    rifd_word_t instr;
    rifd_fp_issue_t fp_done;
    int err_total = 0;
    int tests_run = 0;
    int i;

    rifd_datapath #(.FP_PRESENT(1), .FP_DOUBLE(0)) u_rifd_datapath (.clock_i(clock_i), .srst_i(srst_i),
        .ce_i(ce_i), .instr_valid_i(instr_valid), .instr_i(instr), .load_data_i(load_data), .load_en_i(load_en),
        .load_dst_i(load_dst), .stack_op_i(stack_op), .stack_push_data_i(push_data), .seq_field_o(seq_field),
        .cond_o(cond), .result_o(result), .tos_o(tos), .stack_overflow_o(ovf), .stack_underflow_o(unf),
        .md_busy_o(busy), .fp_done_o(fp_done), .product_high_o(phi), .product_low_o(plo));
    rifd_seq_model u_rifd_seq_model (.clock_i(clock_i), .md_busy_i(busy), .instr_valid_o(instr_valid),
        .instr_o(instr), .stack_op_o(stack_op), .stack_push_data_o(push_data));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic ld(input logic [4:0] r, input logic [31:0] v);
        @(negedge clock_i);
        load_en = 1'b1;
        load_dst = r;
        load_data = v;
        @(negedge clock_i);
        load_en = 1'b0;
        load_data = ~v;
    endtask
    task automatic op(input rifd_op_t o, input logic [4:0] a, input logic [4:0] b, input logic [4:0] d,
                      input logic [2:0] x);
        rifd_word_t w;
        w = '0;
        w.seq = 8'hA5;
        w.intf = {o, a, b, d, x};
        u_rifd_seq_model.issue(w);
    endtask
    task automatic test_done;
        if (err_total == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_arith;
        ld(5'h01, 32'h5);
        ld(5'h02, 32'h7);
        op(RIFD_OP_ADD, 5'h01, 5'h02, 5'h03, 3'h0);
        chk("add", result, 32'hC);
        chk("add cond", {31'h0, cond}, 32'h0);
        op(RIFD_OP_SUB, 5'h01, 5'h01, 5'h04, 3'h0);
        chk("sub cond", {31'h0, cond}, 32'h1);
        op(RIFD_OP_ADDI, 5'h01, 5'h1F, 5'h05, 3'h0);
        chk("addi", result, 32'h24);
        ld(5'h06, 32'hFFFFFFFF);
        op(RIFD_OP_ADD, 5'h06, 5'h01, 5'h07, 3'h0);
        op(RIFD_OP_MOVFROM, 5'h00, 5'h00, 5'h08, 3'h4);
        chk("carry set", result, 32'h1);
        op(RIFD_OP_LOGIC, 5'h01, 5'h02, 5'h09, 3'h3);
        op(RIFD_OP_MOVFROM, 5'h00, 5'h00, 5'h08, 3'h4);
        chk("carry kept", result, 32'h1);
        op(RIFD_OP_ADDC, 5'h01, 5'h02, 5'h0A, 3'h0);
        chk("addc", result, 32'hD);
        ce_i = 1'b0;
        op(RIFD_OP_ADD, 5'h01, 5'h01, 5'h0A, 3'h0);
        ce_i = 1'b1;
        chk("frozen", result, 32'hD);
    endtask
    task automatic t_logic;
        logic [3:0] f;
        ld(5'h01, 32'hC);
        ld(5'h02, 32'hA);
        for (int k = 0; k < 16; k++) begin
            f = 4'(k);
            op(RIFD_OP_LOGIC, 5'h01, 5'h02, {f[0], 4'h5}, f[3:1]);
            chk("logic", result, {{28{f[0]}}, f});
        end
    endtask
    task automatic t_field;
        ld(5'h03, 32'h00000F30);
        op(RIFD_OP_EXT, 5'h03, 5'h04, 5'h08, 3'h0);
        chk("ext zero", result, 32'hF3);
        op(RIFD_OP_EXT, 5'h03, 5'h04, 5'h08, 3'h1);
        chk("ext sign", result, 32'hFFFFFFF3);
        op(RIFD_OP_EXT, 5'h03, 5'h00, 5'h00, 3'h0);
        chk("ext full", result, 32'h00000F30);
        ld(5'h04, 32'hAB);
        op(RIFD_OP_DEP, 5'h04, 5'h08, 5'h04, 3'h0);
        chk("deposit", result, 32'h00000B00);
        ld(5'h04, 32'hAB);
        ld(5'h09, 32'hFFFFFFFF);
        op(RIFD_OP_MOVTO, 5'h09, 5'h00, 5'h00, 3'h1);
        op(RIFD_OP_MRG, 5'h04, 5'h08, 5'h04, 3'h0);
        chk("merge", result, 32'hFFFFFBFF);
        repeat (2) @(negedge clock_i);
        chk("merge target", plo, 32'hFFFFFFFF);
        ld(5'h0A, 32'h8);
        ld(5'h0B, 32'h4);
        op(RIFD_OP_MOVTO, 5'h0A, 5'h00, 5'h00, 3'h2);
        op(RIFD_OP_MOVTO, 5'h0B, 5'h00, 5'h00, 3'h3);
        op(RIFD_OP_EXTD, 5'h03, 5'h00, 5'h0C, 3'h0);
        chk("ext dynamic", result, 32'hF3);
    endtask
    task automatic t_muldiv;
        ld(5'h01, 32'hFFFFFFFD);
        ld(5'h02, 32'h7);
        op(RIFD_OP_MUL, 5'h01, 5'h02, 5'h00, 3'h0);
        op(RIFD_OP_ADD, 5'h02, 5'h02, 5'h05, 3'h0);
        chk("add beside mul", result, 32'hE);
        repeat (5) @(negedge clock_i);
        chk("mul early", plo, 32'hFFFFFFFF);
        repeat (3) @(negedge clock_i);
        chk("mul high", phi, 32'hFFFFFFFF);
        chk("mul low", plo, 32'hFFFFFFEB);
        ld(5'h01, 32'd100);
        ld(5'h0C, 32'h0);
        op(RIFD_OP_MOVTO, 5'h0C, 5'h00, 5'h00, 3'h0);
        op(RIFD_OP_DIV, 5'h01, 5'h02, 5'h00, 3'h0);
        repeat (19) @(negedge clock_i);
        chk("div early", plo, 32'hFFFFFFEB);
        repeat (3) @(negedge clock_i);
        chk("div quotient", plo, 32'hE);
        chk("div remainder", phi, 32'h2);
    endtask
    task automatic t_float;
        rifd_word_t w;
        w = '0;
        w.fpf = 32'h0000_0021;
        u_rifd_seq_model.issue(w);
        chk("fp pending", {31'h0, fp_done.valid}, 32'h0);
        repeat (2) @(negedge clock_i);
        chk("fp done", {26'h0, fp_done.valid, fp_done.dst}, {26'h0, 1'b1, 5'h01});
    endtask
    task automatic t_stack;
        for (i = 1; i <= 33; i++) u_rifd_seq_model.stack(2'b01, i);
        chk("stack full", tos, 32'd33);
        u_rifd_seq_model.stack(2'b01, 32'd99);
        chk("overflow", {31'h0, ovf}, 32'h1);
        @(negedge clock_i);
        chk("overflow end", {31'h0, ovf}, 32'h0);
        chk("tos kept", tos, 32'd33);
        for (i = 33; i >= 2; i--) begin
            u_rifd_seq_model.stack(2'b10, 32'h0);
            chk("pop", tos, i - 1);
        end
        u_rifd_seq_model.stack(2'b10, 32'h0);
        chk("last pop", {31'h0, unf}, 32'h0);
        u_rifd_seq_model.stack(2'b10, 32'h0);
        chk("underflow", {31'h0, unf}, 32'h1);
    endtask

    // ------------------------------------------------------------
    // clock, reset, sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        clock_i = 1'b0;
        forever #4 clock_i = ~clock_i;
    end
    initial begin
        srst_i = 1'b1;
        ce_i = 1'b1;
        load_en = 1'b0;
        load_dst = 5'h00;
        load_data = 32'h0;
        repeat (16) @(negedge clock_i);
        srst_i = 1'b0;
        t_arith;
        t_logic;
        t_field;
        t_muldiv;
        t_stack;
        t_float;
        test_done;
    end
    initial begin
        #200000;
        err_total++;
        test_done;
    end
endmodule
